// ===== dcpid_regulator.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - the running coordinate follows the motion settings and commands.
// - error is running coordinate minus measured encoder coordinate.
// - action is kp*error plus ki*error sum plus kd*error change.
// - fill is action times nominal over supply volts and counts per rev.
// - the winding pwm fill equals the normalised regulator output.
// - each gain is unsigned 0 to 65535 and applied with internal scaling.
// - kp of one at nominal supply fills fully at 256 revs of error.
// - ki of one at nominal supply fills fully at 52.5 rev-seconds of sum.
// - kd of one at nominal supply fills fully at 96000 rpm speed excess.
// - a move is done when the shaft reaches target, oscillation aside.
// - after a hard or limit stop the loop keeps regulating to position.
// - with acceleration off a smooth stop acts as an immediate stop.
module dcpid_regulator
  import dcpid_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic [GAIN_W-1:0]       gainP,
  input  wire logic [GAIN_W-1:0]       gainI,
  input  wire logic [GAIN_W-1:0]       gainD,
  input  wire logic signed [POS_W-1:0] encoderPos,
  input  wire logic [VOLT_W-1:0]       supplyVolt,
  input  wire logic [VOLT_W-1:0]       nominalVolt,
  input  wire logic [VOLT_W-1:0]       encoderCountsPerRev,
  input  wire logic                    moveCmd,
  input  wire logic [POS_W-1:0]        moveTarget,
  input  wire logic [SPD_W-1:0]        maxSpeed,
  input  wire logic [SPD_W-1:0]        accelStep,
  input  wire logic                    accelEnable,
  input  wire logic                    stopCmd,
  input  wire logic                    smoothStopCmd,
  input  wire logic                    limitStop,
  output logic                         pwmOut,
  output logic                         pwmDir,
  output logic [PWM_W:0]               pwmFillFactor,
  output logic [POS_W-1:0]             runPos,
  output logic                         moveDone
);

  // term scales, all referred to p units where full fill is 256 revs
  localparam longint      TS_NS = longint'(SAMPLE_CYCLES) * CLK_PERIOD_NS;
  localparam dcpid_wide_t I_NUM = dcpid_wide_t'(TS_NS * P_FULL_REVS);
  localparam dcpid_wide_t I_DEN = dcpid_wide_t'(I_FULL_REV_MS * NS_PER_MS);
  localparam dcpid_wide_t D_MUL =
    dcpid_wide_t'(NS_PER_MIN * P_FULL_REVS / (D_FULL_RPM * TS_NS));
  localparam logic [31:0] TICK_LAST = 32'(SAMPLE_CYCLES - 1);

  function automatic logic signed [ACC_W-1:0] satAdd(
    input logic signed [ACC_W-1:0] a,
    input logic signed [POS_W-1:0] b
  );
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + (ACC_W+1)'(b);
    if (s > (ACC_W+1)'(ACC_MAX)) begin
      return ACC_MAX;
    end else if (s < (ACC_W+1)'(ACC_MIN)) begin
      return ACC_MIN;
    end
    return s[ACC_W-1:0];
  endfunction

  logic [31:0]                sampleCnt_r;
  logic                       tick_r;
  dcpid_prof_t                prof_r;
  logic [SPD_W-1:0]           speed_r;
  logic [POS_W-1:0]           target_r;
  logic                       dirUp_r;
  logic                       stopNow;
  logic [POS_W-1:0]           remain;
  logic [SPD_W:0]             vUp;
  logic [SPD_W-1:0]           vNxt;
  logic [POS_W-1:0]           step;
  logic [POS_W-1:0]           posNxt;
  logic [49:0]                brakeDist;
  logic                       brake;
  dcpid_calc_t                calc_r;
  logic signed [POS_W-1:0]    err_r;
  logic signed [POS_W:0]      dErr_r;
  logic signed [ACC_W-1:0]    acc_r;
  logic signed [POS_W-1:0]    errNow;
  dcpid_wide_t                pTerm_r;
  dcpid_wide_t                iTerm_r;
  dcpid_wide_t                dTerm_r;
  dcpid_wide_t                uSum_r;
  dcpid_wide_t                uMag;
  logic [47:0]                uClip;
  logic [NUM_W-1:0]           rem_r;
  logic [DEN_W-1:0]           den_r;
  logic [NUM_W-1:0]           denShift;
  logic [3:0]                 bitIdx_r;
  logic [PWM_W:0]             quot_r;
  logic                       neg_r;
  logic                       dirNeg_r;

  // sample tick, one pulse per regulator period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sampleCnt_r <= '0;
      tick_r      <= 1'b0;
    end else begin
      tick_r <= (sampleCnt_r == TICK_LAST);
      if (sampleCnt_r == TICK_LAST) begin
        sampleCnt_r <= '0;
      end else begin
        sampleCnt_r <= sampleCnt_r + 32'h1;
      end
    end
  end

  // immediate stop; smooth stop degrades to it with ramps off
  assign stopNow = stopCmd | limitStop |
                   (smoothStopCmd & ~accelEnable);

  // trapezoid step: brake once 2*a*remaining reaches v*v
  always_comb begin
    remain    = dirUp_r ? target_r - runPos : runPos - target_r;
    vUp       = {1'b0, speed_r} + {1'b0, accelStep};
    brakeDist = 50'(accelStep) * 50'(remain);
    brake     = (prof_r == PRF_BRAKE) ||
                ({brakeDist[48:0], 1'b0} <= 50'(speed_r) * 50'(speed_r));
    if (!accelEnable) begin
      vNxt = maxSpeed;
    end else if (brake) begin
      // creep at one count so a braking move still lands on target
      if (speed_r > accelStep) begin
        vNxt = speed_r - accelStep;
      end else begin
        vNxt = (prof_r == PRF_BRAKE) ? 16'h0000 : 16'h0001;
      end
    end else begin
      vNxt = (vUp > {1'b0, maxSpeed}) ? maxSpeed : vUp[SPD_W-1:0];
    end
    step   = (remain < 32'(vNxt)) ? remain : 32'(vNxt);
    posNxt = dirUp_r ? runPos + step : runPos - step;
  end

  // running coordinate generator
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prof_r   <= PRF_IDLE;
      speed_r  <= '0;
      target_r <= POS_RST;
      dirUp_r  <= 1'b1;
      runPos   <= POS_RST;
    end else if (stopNow) begin
      // setpoint freezes; the loop still pulls the shaft back
      prof_r   <= PRF_IDLE;
      speed_r  <= '0;
      target_r <= runPos;
    end else if (moveCmd) begin
      prof_r   <= PRF_MOVE;
      speed_r  <= '0;
      target_r <= moveTarget;
      dirUp_r  <= ($signed(moveTarget) >= $signed(runPos));
    end else if (smoothStopCmd && prof_r == PRF_MOVE) begin
      prof_r <= PRF_BRAKE;
    end else if (tick_r && prof_r != PRF_IDLE) begin
      runPos  <= posNxt;
      speed_r <= vNxt;
      if (step == remain || vNxt == 16'h0000) begin
        prof_r   <= PRF_IDLE;
        speed_r  <= '0;
        target_r <= posNxt;
      end
    end
  end

  // done once the profile is idle and the shaft sits on the target
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      moveDone <= 1'b0;
    end else if (moveCmd && !stopNow) begin
      moveDone <= 1'b0;
    end else if (prof_r == PRF_IDLE && encoderPos == $signed(target_r)) begin
      moveDone <= 1'b1;
    end
  end

  assign errNow = $signed(runPos) - encoderPos;

  // magnitude and normaliser operands
  always_comb begin
    uMag     = (uSum_r < 0) ? -uSum_r : uSum_r;
    uClip    = (|uMag[WIDE_W-1:48]) ? {48{1'b1}} : uMag[47:0];
    denShift = NUM_W'(den_r) << bitIdx_r;
  end

  // regulator pipeline, started by each sample tick
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      calc_r        <= CALC_IDLE;
      err_r         <= '0;
      dErr_r        <= '0;
      acc_r         <= '0;
      pTerm_r       <= '0;
      iTerm_r       <= '0;
      dTerm_r       <= '0;
      uSum_r        <= '0;
      rem_r         <= '0;
      den_r         <= '0;
      bitIdx_r      <= DIV_LAST;
      quot_r        <= '0;
      neg_r         <= 1'b0;
      dirNeg_r      <= 1'b0;
      pwmFillFactor <= '0;
    end else begin
      case (calc_r)
        CALC_IDLE: begin
          if (tick_r) begin
            err_r  <= errNow;
            dErr_r <= (POS_W+1)'(errNow) - (POS_W+1)'(err_r);
            acc_r  <= satAdd(acc_r, errNow);
            calc_r <= CALC_TERMS;
          end
        end
        CALC_TERMS: begin
          // gains enter zero-extended, so 0..65535 all apply
          pTerm_r <= dcpid_wide_t'($signed({1'b0, gainP})) *
                     dcpid_wide_t'(err_r);
          iTerm_r <= dcpid_wide_t'($signed({1'b0, gainI})) *
                     dcpid_wide_t'(acc_r) * I_NUM / I_DEN;
          dTerm_r <= dcpid_wide_t'($signed({1'b0, gainD})) *
                     dcpid_wide_t'(dErr_r) * D_MUL;
          calc_r  <= CALC_SUM;
        end
        CALC_SUM: begin
          uSum_r <= pTerm_r + iTerm_r + dTerm_r;
          calc_r <= CALC_NORM;
        end
        CALC_NORM: begin
          // fill = |u| * unom * full / (usupp * counts * 256)
          rem_r    <= NUM_W'(uClip) * NUM_W'(nominalVolt) *
                      NUM_W'(PWM_FULL);
          den_r    <= DEN_W'(supplyVolt) * DEN_W'(encoderCountsPerRev) *
                      DEN_W'(P_FULL_REVS);
          neg_r    <= (uSum_r < 0);
          bitIdx_r <= DIV_LAST;
          quot_r   <= '0;
          calc_r   <= CALC_DIV;
        end
        CALC_DIV: begin
          if (den_r == '0) begin
            // no supply or no encoder scale: keep the winding off
            quot_r <= '0;
            calc_r <= CALC_OUT;
          end else if (bitIdx_r == DIV_LAST &&
                       rem_r >= (NUM_W'(den_r) << (PWM_W))) begin
            quot_r <= PWM_FULL;
            calc_r <= CALC_OUT;
          end else begin
            // restoring divide, one quotient bit per cycle
            if (rem_r >= denShift) begin
              rem_r            <= rem_r - denShift;
              quot_r[bitIdx_r] <= 1'b1;
            end
            if (bitIdx_r == 4'h0) begin
              calc_r <= CALC_OUT;
            end else begin
              bitIdx_r <= bitIdx_r - 4'h1;
            end
          end
        end
        CALC_OUT: begin
          pwmFillFactor <= quot_r;
          dirNeg_r      <= neg_r && (quot_r != '0);
          calc_r        <= CALC_IDLE;
        end
        default: begin
          calc_r <= CALC_IDLE;
        end
      endcase
    end
  end

  dcpid_pwm u_pwm (
    .clock  (clock),
    .nrst   (nrst),
    .duty   (pwmFillFactor),
    .dirNeg (dirNeg_r),
    .pwmOut (pwmOut),
    .pwmDir (pwmDir)
  );

endmodule
`default_nettype wire

// ===== dcpid_pkg.sv
package dcpid_pkg;

  // datapath widths, fixed
  localparam int POS_W  = 32;
  localparam int GAIN_W = 16;
  localparam int VOLT_W = 16;
  localparam int SPD_W  = 16;
  localparam int ACC_W  = 40;
  localparam int PWM_W  = 10;
  localparam int WIDE_W = 96;
  localparam int NUM_W  = 74;
  localparam int DEN_W  = 40;

  // pwm full scale, one period in clock cycles
  localparam logic [PWM_W:0]   PWM_FULL   = 11'h400;
  localparam logic [PWM_W-1:0] PWM_CNT_RST = 10'h000;

  // clock and regulator sample period
  localparam longint CLK_PERIOD_NS     = 5;
  localparam longint SAMPLE_TIME_US    = 1000;
  localparam longint NS_PER_US         = 1000;
  localparam int     SAMPLE_CYCLES_DEF =
    int'(SAMPLE_TIME_US * NS_PER_US / CLK_PERIOD_NS);

  // full-fill reference points of the three terms
  localparam longint P_FULL_REVS   = 256;
  localparam longint I_FULL_REV_MS = 52500;
  localparam longint D_FULL_RPM    = 96000;
  localparam longint NS_PER_MS     = 1000000;
  localparam longint NS_PER_MIN    = 64'hdf8475800;

  // accumulator limits and reset values
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
  localparam logic [POS_W-1:0] POS_RST  = 32'h0000_0000;
  localparam logic [3:0]       DIV_LAST = 4'h9;

  typedef logic signed [WIDE_W-1:0] dcpid_wide_t;

  typedef enum logic [1:0] {
    PRF_IDLE,
    PRF_MOVE,
    PRF_BRAKE
  } dcpid_prof_t;

  typedef enum logic [2:0] {
    CALC_IDLE,
    CALC_TERMS,
    CALC_SUM,
    CALC_NORM,
    CALC_DIV,
    CALC_OUT
  } dcpid_calc_t;

endpackage

// ===== dcpid_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module dcpid_pwm
  import dcpid_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [PWM_W:0]   duty,
  input  wire logic             dirNeg,
  output logic                  pwmOut,
  output logic                  pwmDir
);

  logic [PWM_W-1:0] cnt_r;
  logic [PWM_W:0]   dutyHold_r;
  logic             dirHold_r;

  // duty and polarity only change at period start, no runt pulses
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r      <= PWM_CNT_RST;
      dutyHold_r <= '0;
      dirHold_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 10'h001;
      if (cnt_r == PWM_CNT_RST) begin
        dutyHold_r <= duty;
        dirHold_r  <= dirNeg;
      end
    end
  end

  // registered drive, high for duty counts of each period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwmOut <= 1'b0;
      pwmDir <= 1'b0;
    end else begin
      pwmOut <= ({1'b0, cnt_r} < dutyHold_r);
      pwmDir <= dirHold_r;
    end
  end

endmodule
`default_nettype wire

// ===== dcpid_regulator_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcpid_regulator_asserts
  import dcpid_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
  input wire logic                    clock,
  input wire logic                    nrst,
  input wire logic                    moveCmd,
  input wire logic                    stopCmd,
  input wire logic                    smoothStopCmd,
  input wire logic                    limitStop,
  input wire logic                    accelEnable,
  input wire logic signed [POS_W-1:0] encoderPos,
  input wire logic                    pwmOut,
  input wire logic                    pwmDir,
  input wire logic [PWM_W:0]          pwmFillFactor,
  input wire logic [POS_W-1:0]        runPos,
  input wire logic                    moveDone
);
  logic [15:0] zeroRun_r;
  logic [15:0] fullRun_r;
  logic [31:0] fillGap_r;
  logic [31:0] posGap_r;
  logic        frozen_r;
  logic        stopAny;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // smooth stop without ramps counts as a hard stop
  assign stopAny = stopCmd || limitStop || (smoothStopCmd && !accelEnable);

  // how long the fill has sat at zero or full; capped so it never wraps
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      zeroRun_r <= 16'h0000;
      fullRun_r <= 16'h0000;
    end else begin
      zeroRun_r <= (pwmFillFactor != 11'h000) ? 16'h0000 :
                   zeroRun_r + 16'(zeroRun_r < 16'h0800);
      fullRun_r <= (pwmFillFactor != PWM_FULL) ? 16'h0000 :
                   fullRun_r + 16'(fullRun_r < 16'h0800);
    end
  end

  // cycles since the last change of fill and setpoint
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fillGap_r <= 32'(SAMPLE_CYCLES);
      posGap_r  <= 32'(SAMPLE_CYCLES);
    end else begin
      fillGap_r <= $changed(pwmFillFactor) ? 32'h1 : fillGap_r + 32'h1;
      posGap_r  <= $changed(runPos) ? 32'h1 : posGap_r + 32'h1;
    end
  end

  // setpoint frozen from a hard stop until the next move
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) frozen_r <= 1'b0;
    else if (stopAny) frozen_r <= 1'b1;
    else if (moveCmd) frozen_r <= 1'b0;
  end

  fill_range_a: assert property (pwmFillFactor <= PWM_FULL)
    else $error("fill above full scale");
  zero_drive_a: assert property (
      zeroRun_r > 16'h044c |-> !pwmOut && !pwmDir)
    else $error("winding driven at zero fill");
  full_drive_a: assert property (fullRun_r > 16'h044c |-> pwmOut)
    else $error("winding idle at full fill");
  fill_gap_a: assert property (
      $changed(pwmFillFactor) |->
      fillGap_r >= SAMPLE_CYCLES - 32'h0000_000a)
    else $error("fill updated twice in one sample");
  pos_gap_a: assert property (
      $changed(runPos) |-> posGap_r >= SAMPLE_CYCLES)
    else $error("setpoint moved between samples");
  done_clear_a: assert property (moveCmd && !stopAny |=> !moveDone)
    else $error("done kept after new move");
  done_rise_a: assert property (
      $rose(moveDone) |-> $past(encoderPos) == runPos)
    else $error("done raised away from target");
  stop_freeze_a: assert property (
      frozen_r |-> $stable(runPos))
    else $error("setpoint moved after stop");

  cover property ($rose(moveDone));
  cover property (fullRun_r > 16'h044c);
  cover property (frozen_r && $rose(moveDone));
endmodule
bind dcpid_regulator dcpid_regulator_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (
  .clock(clock), .nrst(nrst), .moveCmd(moveCmd), .stopCmd(stopCmd),
  .smoothStopCmd(smoothStopCmd), .limitStop(limitStop),
  .accelEnable(accelEnable), .encoderPos(encoderPos), .pwmOut(pwmOut),
  .pwmDir(pwmDir), .pwmFillFactor(pwmFillFactor), .runPos(runPos),
  .moveDone(moveDone));
`default_nettype wire

// ===== dcpid_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcpid_motor_model
  import dcpid_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    pwmOut,
  input  wire logic                    pwmDir,
  input  wire logic                    hold,
  input  wire logic signed [POS_W-1:0] presetPos,
  output logic signed [POS_W-1:0]      encoderPos
);
  logic [3:0] slip_r;

  // shaft with inertia: one count per 16 driven cycles, so it lags and
  // overshoots; hold clamps the shaft where the bench puts it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slip_r     <= 4'h0;
      encoderPos <= presetPos;
    end else if (hold) begin
      slip_r     <= 4'h0;
      encoderPos <= presetPos;
    end else if (pwmOut) begin
      slip_r <= slip_r + 4'h1;
      if (slip_r == 4'hf) begin
        encoderPos <= pwmDir ? encoderPos - 1 : encoderPos + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_dc_motor_position_pid.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dc_motor_position_pid;
  import dcpid_pkg::*;
  localparam int SC = 2000;
  logic                    clock = 1'b0;
  logic                    nrst = 1'b0;
  logic [GAIN_W-1:0]       gainP = '0, gainI = '0, gainD = '0;
  logic [VOLT_W-1:0]       supplyVolt = 16'h0064, nominalVolt = 16'h0064;
  logic [VOLT_W-1:0]       countsPerRev = 16'h0004;
  logic                    moveCmd = 1'b0, stopCmd = 1'b0, hold = 1'b1;
  logic                    smoothStopCmd = 1'b0, limitStop = 1'b0;
  logic                    accelEnable = 1'b0;
  logic [SPD_W-1:0]        maxSpeed = 16'h0064, accelStep = 16'h000a;
  logic [POS_W-1:0]        moveTarget = '0;
  logic signed [POS_W-1:0] presetPos = '0;
  logic signed [POS_W-1:0] encoderPos;
  logic                    pwmOut, pwmDir, moveDone;
  logic [PWM_W:0]          pwmFillFactor;
  logic [POS_W-1:0]        runPos, lastPos;
  int                      n_errors = 0, n_tests = 0;

  always #2.5 clock = ~clock;

  dcpid_regulator #(.SAMPLE_CYCLES(SC)) dut_u (
    .clock(clock), .nrst(nrst), .gainP(gainP), .gainI(gainI), .gainD(gainD),
    .encoderPos(encoderPos), .supplyVolt(supplyVolt),
    .nominalVolt(nominalVolt), .encoderCountsPerRev(countsPerRev),
    .moveCmd(moveCmd), .moveTarget(moveTarget), .maxSpeed(maxSpeed),
    .accelStep(accelStep), .accelEnable(accelEnable), .stopCmd(stopCmd),
    .smoothStopCmd(smoothStopCmd), .limitStop(limitStop), .pwmOut(pwmOut),
    .pwmDir(pwmDir), .pwmFillFactor(pwmFillFactor), .runPos(runPos),
    .moveDone(moveDone));

  dcpid_motor_model motor_u (
    .clock(clock), .nrst(nrst), .pwmOut(pwmOut), .pwmDir(pwmDir),
    .hold(hold), .presetPos(presetPos), .encoderPos(encoderPos));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic resetDut();
    nrst = 1'b0;
    cyc(16);
    nrst = 1'b1;
  endtask

  // bounded wait for the setpoint or the fill to move
  task automatic waitSig(input bit pos);
    logic [POS_W-1:0] was;
    was = pos ? runPos : POS_W'(pwmFillFactor);
    repeat (3 * SC) begin
      cyc(1);
      if ((pos ? runPos : POS_W'(pwmFillFactor)) !== was) return;
    end
    check("change", 32'h1, 32'h0);
  endtask

  // proportional path against a clamped shaft: gain, error, supply, nominal
  task automatic test_fill();
    int tab [8][6] = '{
      '{1, -512, 100, 100, 512, 0}, '{1, 2048, 100, 100, 1024, 1},
      '{1, -512, 200, 100, 256, 0}, '{1, -512, 100, 200, 1024, 0},
      '{65535, -1, 100, 100, 1024, 0}, '{3, -100, 100, 100, 300, 0},
      '{1, -512, 0, 100, 0, 0}, '{0, 2048, 100, 100, 0, 0}};
    logic [31:0] hi;
    for (int i = 0; i < 8; i++) begin
      gainP = GAIN_W'(tab[i][0]);
      presetPos = tab[i][1];
      supplyVolt = VOLT_W'(tab[i][2]);
      nominalVolt = VOLT_W'(tab[i][3]);
      cyc(SC + 1100);
      check("fill", tab[i][4], pwmFillFactor);
      check("dir", tab[i][5], pwmDir);
      hi = '0;
      repeat (1024) begin
        cyc(1);
        hi += 32'(pwmOut);
      end
      check("duty", tab[i][4], hi);
    end
    supplyVolt = 16'h0064;
    nominalVolt = 16'h0064;
    $display("fill test done");
  endtask

  // integral only: one sample of this error is half of full fill
  task automatic test_integral();
    gainP = '0;
    gainI = 16'h0001;
    presetPos = -32'sh00a0_37a0;
    resetDut();
    waitSig(0);
    check("int fill", 32'h200, pwmFillFactor);
    waitSig(0);
    check("int fill", 32'h400, pwmFillFactor);
    $display("integral test done");
  endtask

  // derivative only: one count of change saturates for one sample
  task automatic test_deriv();
    gainI = '0;
    gainD = 16'h0001;
    presetPos = '0;
    resetDut();
    cyc(SC);
    presetPos = 32'sh1;
    waitSig(0);
    check("der fill", 32'h400, pwmFillFactor);
    cyc(1100);
    check("der dir", 32'h1, pwmDir);
    waitSig(0);
    check("der fill", 32'h0, pwmFillFactor);
    $display("derivative test done");
  endtask

  // each stop kind freezes the setpoint mid move; done follows the shaft
  task automatic test_stops();
    gainD = '0;
    presetPos = '0;
    resetDut();
    for (int k = 0; k < 3; k++) begin
      lastPos = runPos;
      moveTarget = runPos + 32'h3e8;
      moveCmd = 1'b1;
      cyc(1);
      moveCmd = 1'b0;
      waitSig(1);
      check("step", lastPos + 32'h64, runPos);
      lastPos = runPos;
      {limitStop, smoothStopCmd, stopCmd} = 3'b001 << k;
      cyc(1);
      {limitStop, smoothStopCmd, stopCmd} = 3'b000;
      cyc(2 * SC + 10);
      check("frozen", lastPos, runPos);
    end
    check("done early", 32'h0, moveDone);
    presetPos = runPos;
    cyc(4);
    check("done", 32'h1, moveDone);
    $display("stop test done");
  endtask

  // ramps on: speed climbs one step a sample, a smooth stop brakes to rest
  task automatic test_ramp();
    accelEnable = 1'b1;
    lastPos = runPos;
    moveTarget = runPos + 32'h3e8;
    moveCmd = 1'b1;
    cyc(1);
    moveCmd = 1'b0;
    waitSig(1);
    check("ramp", lastPos + 32'h0a, runPos);
    waitSig(1);
    check("ramp", lastPos + 32'h1e, runPos);
    smoothStopCmd = 1'b1;
    cyc(1);
    smoothStopCmd = 1'b0;
    waitSig(1);
    check("brake", lastPos + 32'h28, runPos);
    cyc(2 * SC + 10);
    check("rest", lastPos + 32'h28, runPos);
    accelEnable = 1'b0;
    presetPos = runPos;
    cyc(4);
    check("ramp done", 32'h1, moveDone);
    $display("ramp test done");
  endtask

  // closed loop through the motor model until the shaft hits the target
  task automatic test_follow();
    gainP = 16'h0400;
    hold = 1'b0;
    moveTarget = runPos + 32'h12c;
    moveCmd = 1'b1;
    cyc(1);
    moveCmd = 1'b0;
    cyc(1);
    check("done clear", 32'h0, moveDone);
    for (int i = 0; i < 12000 && moveDone !== 1'b1; i++) cyc(1);
    check("reached", 32'h1, moveDone);
    check("setpoint", moveTarget, runPos);
    $display("follow test done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard: a little above the summed length of all tests
  initial begin
    repeat (95000) @(posedge clock);
    n_errors++;
    stop_test();
  end

  initial begin
    resetDut();
    test_fill();
    test_integral();
    test_deriv();
    test_stops();
    test_ramp();
    test_follow();
    stop_test();
  end
endmodule
`default_nettype wire
